// file: verilog/ewg_defs.vh
// Constants for the serial EEPROM write guard
`ifndef EWG_DEFS_VH
`define EWG_DEFS_VH
`define EWG_CLK_PERIOD_NS 50
`define EWG_GLITCH_NS 20
// Cycles a level must hold before it is accepted: more than 20 ns means at least one full cycle
`define EWG_GLITCH_CYC ((`EWG_GLITCH_NS / `EWG_CLK_PERIOD_NS) + 1)
`define EWG_ADDR_W 10
`define EWG_DATA_W 16
// Opcode field (2 bits) after the start bit
`define EWG_OP_EXT 2'b00
`define EWG_OP_WRITE 2'b01
`define EWG_OP_READ 2'b10
`define EWG_OP_ERASE 2'b11
// Upper two address bits select the extended instruction
`define EWG_EXT_DISABLE 2'b00
`define EWG_EXT_CHIPWR 2'b01
`define EWG_EXT_CHIPER 2'b10
`define EWG_EXT_ENABLE 2'b11
// Exact clock count of each frame, start bit included
`define EWG_CNT_SHORT 8'd13
`define EWG_CNT_LONG 8'd29
// Internal write time in core cycles (2 ms at 20 MHz)
`define EWG_WRITE_CYC 16'd40000
`define EWG_ERASED 16'hffff
`endif

// file: verilog/ewg_filter.v
// Glitch filter and synchroniser for one input pin
`timescale 1ns/1ns
module ewg_filter
(
  input wire core_clk,
  input wire reset,
  input wire pin,
  output reg level_q
);
`include "ewg_defs.vh"
  reg s1_q;
  reg s2_q;
  reg [3:0] cnt_q;

  // Two-stage synchroniser
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
    end
  end

  // Accept a new level only after it holds past the glitch time
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_q <= 4'h0;
      level_q <= 1'b0;
    end
    else if (s2_q == level_q)
      cnt_q <= 4'h0;
    else if (cnt_q >= `EWG_GLITCH_CYC)
    begin
      level_q <= s2_q;
      cnt_q <= 4'h0;
    end
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule

// file: verilog/ewg_guard.v
// Instruction decoder with write protection for a serial EEPROM
`timescale 1ns/1ns
module ewg_guard
(
  input wire core_clk,
  input wire reset,
  input wire chip_select,
  input wire serial_clock_in,
  input wire serial_data_in,
  input wire low_supply,
  output reg serial_data_out_q,
  output reg serial_data_oe_n_q,
  output reg busy_q,
  output reg program_enabled_q,
  output reg undefined_word_q
);
`include "ewg_defs.vh"
  localparam ST_IDLE = 4'b0001;
  localparam ST_SHIFT = 4'b0010;
  localparam ST_READ = 4'b0100;
  localparam ST_WRITE = 4'b1000;

  wire cs_f;
  wire sk_f;
  wire di_f;
  reg sk_prev_q;
  reg cs_prev_q;
  reg lv1_q;
  reg lv2_q;
  reg [3:0] state_q;
  reg started_q;
  reg [7:0] cnt_q;
  reg [27:0] sr_q;
  reg [15:0] rd_q;
  reg [4:0] rd_cnt_q;
  reg [`EWG_ADDR_W-1:0] addr_q;
  reg [15:0] wtimer_q;
  reg [15:0] wdata_q;
  reg wall_q;
  reg [`EWG_DATA_W-1:0] mem_q [0:(1<<`EWG_ADDR_W)-1];
  integer i;

  wire sk_rise = sk_f & ~sk_prev_q;
  wire cs_fall = ~cs_f & cs_prev_q;
  // Opcode sits higher in the shift register once a data word has followed it
  wire long_frame = (cnt_q == `EWG_CNT_LONG);
  wire [1:0] op = long_frame ? sr_q[27:26] : sr_q[11:10];
  wire [1:0] ext = long_frame ? sr_q[25:24] : sr_q[9:8];

  // Expected exact count for a write-class frame
  function [7:0] exp_cnt;
    input [1:0] o;
    input [1:0] e;
    begin
      if (o == `EWG_OP_WRITE || (o == `EWG_OP_EXT && e == `EWG_EXT_CHIPWR))
        exp_cnt = `EWG_CNT_LONG;
      else
        exp_cnt = `EWG_CNT_SHORT;
    end
  endfunction

  ewg_filter u_cs (.core_clk(core_clk), .reset(reset), .pin(chip_select), .level_q(cs_f));
  ewg_filter u_sk (.core_clk(core_clk), .reset(reset), .pin(serial_clock_in), .level_q(sk_f));
  ewg_filter u_di (.core_clk(core_clk), .reset(reset), .pin(serial_data_in), .level_q(di_f));

  // Memory contents; no reset so it maps to an array
  always @(posedge core_clk)
  begin
    if (state_q == ST_WRITE && wtimer_q == 16'h0001 && !lv2_q)
    begin
      if (wall_q)
        for (i = 0; i < (1<<`EWG_ADDR_W); i = i + 1)
          mem_q[i] <= wdata_q;
      else
        mem_q[addr_q] <= wdata_q;
    end
  end

  // Edge detect and low-supply synchroniser
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      sk_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
      lv1_q <= 1'b1;
      lv2_q <= 1'b1;
    end
    else
    begin
      sk_prev_q <= sk_f;
      cs_prev_q <= cs_f;
      lv1_q <= low_supply;
      lv2_q <= lv1_q;
    end
  end

  // Frame decoder, write sequencer and mode
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      started_q <= 1'b0;
      cnt_q <= 8'h00;
      sr_q <= 28'h0;
      rd_q <= 16'h0;
      rd_cnt_q <= 5'h0;
      addr_q <= {`EWG_ADDR_W{1'b0}};
      wtimer_q <= 16'h0;
      wdata_q <= 16'h0;
      wall_q <= 1'b0;
      program_enabled_q <= 1'b0;
      busy_q <= 1'b0;
      undefined_word_q <= 1'b0;
      serial_data_out_q <= 1'b0;
      serial_data_oe_n_q <= 1'b1;
    end
    else
    begin
      if (lv2_q)
        program_enabled_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          serial_data_oe_n_q <= 1'b1;
          started_q <= 1'b0;
          cnt_q <= 8'h00;
          if (cs_f && !lv2_q)
            state_q <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          if (lv2_q)
            state_q <= ST_IDLE;
          else if (!cs_f)
          begin
            state_q <= ST_IDLE; // evaluate only on frame end
            if (started_q && op == `EWG_OP_EXT && ext == `EWG_EXT_ENABLE && cnt_q == `EWG_CNT_SHORT)
              program_enabled_q <= 1'b1;
            else if (started_q && op == `EWG_OP_EXT && ext == `EWG_EXT_DISABLE && cnt_q == `EWG_CNT_SHORT)
              program_enabled_q <= 1'b0;
            else if (started_q && op != `EWG_OP_READ && program_enabled_q
                     && cnt_q == exp_cnt(op, ext))
            begin
              state_q <= ST_WRITE;
              busy_q <= 1'b1;
              wtimer_q <= `EWG_WRITE_CYC;
              wall_q <= (op == `EWG_OP_EXT);
              addr_q <= (op == `EWG_OP_EXT) ? addr_q : (cnt_q == `EWG_CNT_LONG ? sr_q[25:16] : sr_q[9:0]);
              wdata_q <= (op == `EWG_OP_WRITE || op == `EWG_OP_EXT && ext == `EWG_EXT_CHIPWR) ?
                         sr_q[15:0] : `EWG_ERASED;
            end
          end
          else if (sk_rise)
          begin
            if (!started_q)
            begin
              if (di_f)
              begin
                started_q <= 1'b1;
                cnt_q <= 8'h01;
                sr_q <= 28'h0;
              end
            end
            else
            begin
              sr_q <= {sr_q[26:0], di_f};
              if (cnt_q != 8'hff)
                cnt_q <= cnt_q + 8'h01;
              if (cnt_q == 8'd12 && sr_q[10:9] == `EWG_OP_READ)
              begin
                state_q <= ST_READ;
                rd_q <= mem_q[{sr_q[8:0], di_f}];
                addr_q <= {sr_q[8:0], di_f};
                rd_cnt_q <= 5'h0;
                serial_data_out_q <= 1'b0;
                serial_data_oe_n_q <= 1'b0;
              end
            end
          end
        end
        ST_READ:
        begin
          if (!cs_f || lv2_q)
          begin
            state_q <= ST_IDLE;
            serial_data_oe_n_q <= 1'b1;
          end
          else if (sk_rise)
          begin
            serial_data_out_q <= rd_q[15];
            rd_q <= {rd_q[14:0], 1'b0};
            rd_cnt_q <= rd_cnt_q + 5'h1;
            if (rd_cnt_q == 5'd15)
            begin
              rd_q <= mem_q[addr_q + 10'h001];
              addr_q <= addr_q + 10'h001;
              rd_cnt_q <= 5'h0;
            end
          end
        end
        ST_WRITE:
        begin
          // Clock and data ignored; chip select shows busy as a low on data out
          serial_data_oe_n_q <= ~cs_f;
          serial_data_out_q <= 1'b0;
          if (lv2_q)
          begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            undefined_word_q <= 1'b1;
          end
          else if (wtimer_q == 16'h0001)
          begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            undefined_word_q <= 1'b0;
          end
          else
            wtimer_q <= wtimer_q - 16'h0001;
        end
        default:
          state_q <= ST_IDLE;
      endcase
      if (cs_fall && state_q == ST_READ)
        serial_data_oe_n_q <= 1'b1;
    end
  end
endmodule

// file: testbench/ewg_guard_monitor.sv
// Port checker for the write guard
`timescale 1ns/1ns
module ewg_guard_monitor
(
  input wire core_clk,
  input wire reset,
  input wire chip_select,
  input wire serial_clock_in,
  input wire serial_data_in,
  input wire low_supply,
  input wire serial_data_out_q,
  input wire serial_data_oe_n_q,
  input wire busy_q,
  input wire program_enabled_q,
  input wire undefined_word_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // Safe state, write start and mode changes
  chk_low_lock: assert property (low_supply [*4] |=> !program_enabled_q && !busy_q)
    else $error("low supply left writes possible");
  chk_write_start: assert property ($rose(busy_q) |-> !chip_select && !$past(chip_select, 3))
    else $error("write began with select high");
  chk_write_mode: assert property ($rose(busy_q) |-> $past(program_enabled_q))
    else $error("write began while disabled");
  chk_select_quiet: assert property ((!chip_select && !busy_q) [*8] |=> !busy_q)
    else $error("write began with select low");
  chk_word_undef: assert property ($rose(undefined_word_q) |-> $past(busy_q))
    else $error("undefined word without a write");
  chk_out_release: assert property (!chip_select [*8] |-> serial_data_oe_n_q)
    else $error("data out driven while deselected");
  chk_mode_edge: assert property ($rose(program_enabled_q) |-> !chip_select && !low_supply)
    else $error("mode changed inside a frame");
  chk_busy_hold: assert property ($rose(busy_q) && !low_supply |=> busy_q [*8])
    else $error("write ended too soon");
  // Main scenarios
  cov_write: cover property ($rose(busy_q));
  cov_enable: cover property ($rose(program_enabled_q));
  cov_abort: cover property ($rose(undefined_word_q));
  cov_read: cover property ($fell(serial_data_oe_n_q) && chip_select);
endmodule

// file: testbench/ewg_host.sv
// Host controller model sending instruction frames
`timescale 1ns/1ns
module ewg_host
(
  input wire core_clk,
  output reg cs,
  output reg sk,
  output reg di
);
  initial {cs, sk, di} = 3'b000;
  task wt(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  // Sends n bits MSB first after d dummy clocks; g adds a 20 ns clock glitch
  task frame(input [31:0] b, input integer n, input integer d, input integer g);
    integer i;
    begin
      cs = 1'b1;
      wt(4);
      for (i = n + d - 1; i >= 0; i = i - 1)
      begin
        di = (i < n) ? b[i] : 1'b0;
        wt(4);
        sk = 1'b1;
        wt(4);
        sk = 1'b0;
        if (g == 1 && i == 3)
        begin
          wt(2);
          #15 sk = 1'b1;
          #20 sk = 1'b0; // straddles one rising edge of core_clk
          wt(1);
        end
      end
      wt(4);
      cs = 1'b0;
      di = 1'b0;
      wt(12);
    end
  endtask
endmodule

// file: testbench/tb_top.sv
// Bench for the serial write guard
`timescale 1ns/1ns
module tb_top;
  reg core_clk, reset, low_supply;
  wire chip_select, serial_clock_in, serial_data_in, serial_data_out_q;
  wire serial_data_oe_n_q, busy_q, program_enabled_q, undefined_word_q;
  integer err_total, n_tests, cyc;
  ewg_guard dut (.core_clk(core_clk), .reset(reset), .chip_select(chip_select),
    .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in), .low_supply(low_supply),
    .serial_data_out_q(serial_data_out_q), .serial_data_oe_n_q(serial_data_oe_n_q), .busy_q(busy_q),
    .program_enabled_q(program_enabled_q), .undefined_word_q(undefined_word_q));
  ewg_host host (.core_clk(core_clk), .cs(chip_select), .sk(serial_clock_in), .di(serial_data_in));
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task check(input [95:0] nm, input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("BAD %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Cuts a hang short
  always @(posedge core_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 60000)
    begin
      err_total = err_total + 1;
      final_report;
    end
  end
  // Enable frame with three dummy clocks
  task t_enable;
    begin
      host.frame(32'h1300, 13, 3, 0);
      check("enabled", program_enabled_q, 1'b1);
    end
  endtask
  // Frames with a wrong clock count start nothing
  task t_count;
    begin
      host.frame(32'h2c00, 14, 0, 0);
      check("busy", busy_q, 1'b0);
      host.frame(32'h0e00, 12, 0, 0);
      check("busy", busy_q, 1'b0);
      host.frame(32'ha000000, 28, 0, 0);
      check("busy", busy_q, 1'b0);
    end
  endtask
  // Clock and data activity with select low
  task t_quiet;
    integer i;
    begin
      for (i = 0; i < 40; i = i + 1)
      begin
        host.wt(4);
        host.sk = ~host.sk;
        host.di = i[1];
      end
      host.di = 1'b0;
      host.wt(8);
      check("busy", busy_q, 1'b0);
    end
  endtask
  // Glitched erase starts, then low supply aborts it
  task t_abort;
    begin
      host.frame(32'h1c00, 13, 0, 1);
      check("busy", busy_q, 1'b1);
      low_supply = 1'b1;
      host.wt(10);
      check("busy", busy_q, 1'b0);
      check("enabled", program_enabled_q, 1'b0);
      check("undef", undefined_word_q, 1'b1);
      low_supply = 1'b0;
      host.wt(10);
      host.frame(32'h1c00, 13, 0, 0);
      check("busy", busy_q, 1'b0);
      host.frame(32'h1300, 13, 0, 0);
      check("enabled", program_enabled_q, 1'b1);
    end
  endtask
  // Full write with busy verify, then the word read back
  task t_rdwr;
    integer i;
    reg [31:0] seq;
    reg [15:0] got;
    begin
      seq = 32'h18050000;
      got = 16'h0000;
      host.frame(32'h14055a3c, 29, 0, 0);
      check("busy", busy_q, 1'b1);
      host.cs = 1'b1;
      host.wt(8);
      check("vfy_oe_n", serial_data_oe_n_q, 1'b0);
      check("vfy_out", serial_data_out_q, 1'b0);
      host.cs = 1'b0;
      host.wt(40000);
      check("busy", busy_q, 1'b0);
      check("undef", undefined_word_q, 1'b0);
      host.cs = 1'b1;
      host.wt(4);
      for (i = 28; i >= 0; i = i - 1)
      begin
        host.di = seq[i];
        host.wt(4);
        host.sk = 1'b1;
        host.wt(4);
        host.sk = 1'b0;
        host.wt(2);
        if (i < 16)
          got[i] = serial_data_out_q;
      end
      check("rd_oe_n", serial_data_oe_n_q, 1'b0);
      host.cs = 1'b0;
      host.di = 1'b0;
      host.wt(12);
      check("oe_n", serial_data_oe_n_q, 1'b1);
      check("rd_data", got, 16'h5a3c);
    end
  endtask
  initial
  begin
    reset = 1'b1;
    low_supply = 1'b0;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    check("enabled", program_enabled_q, 1'b0);
    check("oe_n", serial_data_oe_n_q, 1'b1);
    t_enable;
    t_count;
    t_quiet;
    t_abort;
    t_rdwr;
    final_report;
  end
endmodule
bind ewg_guard ewg_guard_monitor mon (.core_clk(core_clk), .reset(reset), .chip_select(chip_select),
  .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in), .low_supply(low_supply),
  .serial_data_out_q(serial_data_out_q), .serial_data_oe_n_q(serial_data_oe_n_q), .busy_q(busy_q),
  .program_enabled_q(program_enabled_q), .undefined_word_q(undefined_word_q));
